/* src/pcc_host_channel.v */
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_host_channel
(
    input  wire        CLK_SYS_I,
    input  wire        SYS_RST_I,
    input  wire        AQ_READ_N_I,
    input  wire        AQ_WRITE_N_I,
    input  wire        AQ_PROTECT_N_I,
    input  wire [15:0] AQ_Q_I,
    input  wire [15:0] AQ_A_I,
    output reg  [15:0] AQ_A_O,
    output reg         AQ_A_OE_O,
    output reg         AQ_REPLY_O,
    output reg         AQ_REJECT_O,
    output reg         INT_CHAR_O,
    output reg         DONE_INTERRUPT_LINE_O,
    output reg         INT_ALARM_O,
    output reg         INT_COMMON_O,
    input  wire        PRN_READY_I,
    input  wire        PRN_LINE_READY_I,
    input  wire        PRN_CHAR_REQ_I,
    input  wire        PRN_PARITY_ERR_I,
    output reg  [7:0]  PRN_DATA_O,
    output reg         PRN_PARITY_O,
    output reg         PRN_CONTROL_BIT_O,
    output reg         PRN_STROBE_O,
    output reg         PRN_BUFFER_CLEAR_O,
    input  wire [3:0]  REG_ADDR_I,
    input  wire [15:0] REG_WDATA_I,
    input  wire        REG_WR_I,
    input  wire        REG_RD_I,
    output reg  [15:0] REG_RDATA_O
);

    // Odd parity over the character, so an all-zero byte still carries a one
    function odd_parity;
        input [7:0] d;
        begin
            odd_parity = ~(^d);
        end
    endfunction

    wire [3:0]  phase;
    wire [1:0]  strobes;
    wire        rd;
    wire        wr;
    reg         wr_prev;
    reg         rd_prev;
    reg  [15:0] config_reg;
    reg         cycle_start_latch;
    reg         read_delayed;
    reg         reply_reject_latch;
    reg         reply_reject_enable;
    reg  [15:0] a_hold;
    reg         held_char_write;
    reg         held_function;
    reg         char_ready;
    reg         printer_busy;
    reg         end_of_operation;
    reg         parity_err_latch;
    reg         request_char_interrupt;
    reg         request_done_interrupt;
    reg         request_alarm_interrupt;
    reg         done_pending;
    reg         strobe_request;
    reg  [2:0]  strobe_count;
    reg         line_ready_prev;
    reg         char_req_prev;

    pcc_phase_gen u_phase
    (
        .clk_i   (CLK_SYS_I),
        .rst_i   (SYS_RST_I),
        .phase_o (phase)
    );

    // Channel strobes arrive with no relation to our clock
    pcc_sync #(.W(2)) u_sync
    (
        .clk_i   (CLK_SYS_I),
        .rst_i   (SYS_RST_I),
        .async_i ({~AQ_READ_N_I, ~AQ_WRITE_N_I}),
        .sync_o  (strobes)
    );
    assign rd = strobes[1];
    assign wr = strobes[0];

    // Equipment decode: installed jumper means the comparator sees a low
    wire [3:0] jumper_level   = ~config_reg[`PCC_CFG_EQ_MSB:`PCC_CFG_EQ_LSB];
    wire       upper_zero     = ~|AQ_Q_I[`PCC_Q_UPPER_MSB:`PCC_Q_UPPER_LSB];
    wire       equipment_match = (&(~(AQ_Q_I[`PCC_Q_EQ_MSB:`PCC_Q_EQ_LSB] ^ jumper_level)))
                                 & upper_zero;
    wire       addressed      = equipment_match & (rd | wr);

    // Protect is satisfied by the jumper or by the computer's protect line
    wire protect_ok = config_reg[`PCC_CFG_PROTECT_JMP] | ~AQ_PROTECT_N_I;

    // Operation decode, enabled by the cycle start latch
    wire q_op                 = AQ_Q_I[`PCC_Q_OP];
    wire char_write_decode    = wr & ~q_op;
    wire char_write_op        = cycle_start_latch & char_write_decode;
    wire director_function_op = cycle_start_latch & wr & q_op;
    wire director_status_op   = cycle_start_latch & rd & q_op;

    // Execution checks; a read with Q00 clear matches nothing and so rejects
    wire printer_ok    = char_ready & protect_ok & PRN_READY_I & ~printer_busy;
    wire char_write_ok = char_write_op & printer_ok;
    wire print_ok      = director_function_op & AQ_A_I[`PCC_A_PRINT] & printer_ok;
    wire function_ok   = director_function_op & ~AQ_A_I[`PCC_A_PRINT] & protect_ok;
    wire reply_permitted = char_write_ok | print_ok | function_ok
                         | director_status_op;

    wire write_fall = wr_prev & ~wr;
    wire accepted   = reply_reject_enable & reply_reject_latch;
    wire do_char    = write_fall & accepted & held_char_write;
    wire do_func    = write_fall & accepted & held_function;
    wire do_clear   = do_func & a_hold[`PCC_A_CLEAR_CTRL];
    wire do_clr_int = do_func & a_hold[`PCC_A_CLEAR_INT];
    wire do_print   = do_func & a_hold[`PCC_A_PRINT];

    wire line_ready_rise = PRN_LINE_READY_I & ~line_ready_prev;
    wire char_req_rise   = PRN_CHAR_REQ_I & ~char_req_prev;
    wire char_req_fall   = ~PRN_CHAR_REQ_I & char_req_prev;
    wire alarm           = parity_err_latch | ~PRN_READY_I;

    // Interrupt lines, computed here so each output is one flop
    wire next_int_char  = request_char_interrupt & char_ready;
    wire next_int_done  = request_done_interrupt & done_pending;
    wire next_int_alarm = request_alarm_interrupt & alarm;

    wire [15:0] status_word = {8'h00, protect_ok, INT_COMMON_O, parity_err_latch, alarm,
                               end_of_operation, char_ready, printer_busy, PRN_READY_I};

    // Cycle start, read delayed and reply/reject sequencing
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            wr_prev             <= 1'b0;
            rd_prev             <= 1'b0;
            cycle_start_latch   <= 1'b0;
            read_delayed        <= 1'b0;
            reply_reject_latch  <= 1'b0;
            reply_reject_enable <= 1'b0;
            held_char_write     <= 1'b0;
            held_function       <= 1'b0;
            a_hold              <= 16'h0000;
            AQ_REPLY_O          <= 1'b0;
            AQ_REJECT_O         <= 1'b0;
        end
        else
        begin
            wr_prev <= wr;
            rd_prev <= rd;
            if (!rd && !wr)
            begin
                // Dropping the strobe ends the cycle and removes the answer
                cycle_start_latch   <= 1'b0;
                reply_reject_enable <= 1'b0;
                AQ_REPLY_O          <= 1'b0;
                AQ_REJECT_O         <= 1'b0;
            end
            else
            begin
                if (phase[`PCC_T1] && addressed && !cycle_start_latch && !reply_reject_enable)
                begin
                    cycle_start_latch <= 1'b1;
                    if (rd)
                        read_delayed <= 1'b1;
                end
                if (phase[`PCC_T3] && cycle_start_latch && !reply_reject_enable)
                begin
                    reply_reject_latch <= reply_permitted;
                    held_char_write    <= char_write_ok;
                    held_function      <= print_ok | function_ok;
                    a_hold             <= AQ_A_I;
                end
                if (phase[`PCC_T4] && cycle_start_latch && !reply_reject_enable)
                begin
                    reply_reject_enable <= 1'b1;
                    AQ_REPLY_O          <= reply_reject_latch;
                    AQ_REJECT_O         <= ~reply_reject_latch;
                end
            end
            // Read-side release waits until Reply has gone
            if (read_delayed && !rd && !AQ_REPLY_O && !AQ_REJECT_O)
                read_delayed <= 1'b0;
        end
    end

    // Status bits on A: frozen at T3 so they cannot change under Reply
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            AQ_A_O    <= 16'h0000;
            AQ_A_OE_O <= 1'b0;
        end
        else if (phase[`PCC_T3] && director_status_op && !reply_reject_enable)
        begin
            AQ_A_O    <= status_word;
            AQ_A_OE_O <= 1'b1;
        end
        else if (!read_delayed)
        begin
            AQ_A_OE_O <= 1'b0;
        end
    end

    // Printer state: character ready, busy, end of operation, parity error
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            line_ready_prev   <= 1'b1; // Idle level, so no false rise
            char_req_prev     <= 1'b0;
            char_ready        <= 1'b0;
            printer_busy      <= 1'b0;
            end_of_operation  <= 1'b0;
            parity_err_latch  <= 1'b0;
            PRN_DATA_O        <= 8'h00;
            PRN_PARITY_O      <= 1'b0;
            PRN_CONTROL_BIT_O <= 1'b0;
        end
        else
        begin
            line_ready_prev <= PRN_LINE_READY_I;
            char_req_prev   <= PRN_CHAR_REQ_I;
            // A new character request wins over the clear at the end of a write strobe
            if (char_req_rise)
                char_ready <= 1'b1;
            else if (do_char || do_print || do_clear)
                char_ready <= 1'b0;
            // Early busy from print, ended by line ready returning
            if (do_print)
                printer_busy <= 1'b1;
            else if (line_ready_rise || do_clear)
                printer_busy <= 1'b0;
            if (line_ready_rise && printer_busy)
                end_of_operation <= 1'b1;
            else if (do_char || do_clear)
                end_of_operation <= 1'b0;
            // Parity error from the printer beats any clear in the same cycle
            if (PRN_PARITY_ERR_I)
                parity_err_latch <= 1'b1;
            else if (do_char || do_print || do_clear)
                parity_err_latch <= 1'b0;
            if (do_char)
            begin
                PRN_DATA_O   <= a_hold[7:0];
                PRN_PARITY_O <= odd_parity(a_hold[7:0]);
            end
            if (do_print)
                PRN_CONTROL_BIT_O <= 1'b1;
            else if (line_ready_rise || do_clear)
                PRN_CONTROL_BIT_O <= 1'b0;
        end
    end

    // Strobe timing counter, advanced once per round on T4
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            strobe_request     <= 1'b0;
            strobe_count       <= 3'h0;
            PRN_STROBE_O       <= 1'b0;
            PRN_BUFFER_CLEAR_O <= 1'b0;
        end
        else
        begin
            // Buffer clear lasts one phase
            PRN_BUFFER_CLEAR_O <= do_clear;
            if (do_clear || char_req_fall)
            begin
                // Printer took the character or a clear came, so the strobe ends
                strobe_request <= 1'b0;
                strobe_count   <= 3'h0;
                PRN_STROBE_O   <= 1'b0;
            end
            else if (do_char || do_print)
            begin
                strobe_request <= 1'b1;
                strobe_count   <= 3'h0;
            end
            else if (strobe_request && phase[`PCC_T4])
            begin
                if (strobe_count == `PCC_STROBE_T4_COUNT - 3'h1)
                    PRN_STROBE_O <= 1'b1;
                else
                    strobe_count <= strobe_count + 3'h1;
            end
        end
    end

    // Interrupt requests and lines
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            request_char_interrupt  <= 1'b0;
            request_done_interrupt  <= 1'b0;
            request_alarm_interrupt <= 1'b0;
            done_pending            <= 1'b0;
            INT_CHAR_O              <= 1'b0;
            DONE_INTERRUPT_LINE_O   <= 1'b0;
            INT_ALARM_O             <= 1'b0;
            INT_COMMON_O            <= 1'b0;
        end
        else
        begin
            // A set bit wins over clear interrupts in the same function
            if (do_func && a_hold[`PCC_A_RQ_CHAR])
                request_char_interrupt <= 1'b1;
            else if (do_clr_int || do_clear)
                request_char_interrupt <= 1'b0;
            if (do_func && a_hold[`PCC_A_RQ_DONE])
                request_done_interrupt <= 1'b1;
            else if (do_clr_int || do_clear)
                request_done_interrupt <= 1'b0;
            if (do_func && a_hold[`PCC_A_RQ_ALARM])
                request_alarm_interrupt <= 1'b1;
            else if (do_clr_int || do_clear)
                request_alarm_interrupt <= 1'b0;
            // Done interrupts only for a request armed before the print ended
            if (line_ready_rise && printer_busy && request_done_interrupt)
                done_pending <= 1'b1;
            else if (do_clr_int || do_clear || do_char)
                done_pending <= 1'b0;
            INT_CHAR_O            <= next_int_char;
            DONE_INTERRUPT_LINE_O <= next_int_done;
            INT_ALARM_O           <= next_int_alarm;
            INT_COMMON_O          <= next_int_char | next_int_done | next_int_alarm;
        end
    end

    // Local register port: read data stand one cycle after the strobe
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            config_reg  <= `PCC_CONFIG_RESET;
            REG_RDATA_O <= 16'h0000;
        end
        else
        begin
            if (REG_WR_I && REG_ADDR_I == `PCC_REG_CONFIG)
                config_reg <= {11'h000, REG_WDATA_I[4:0]};
            REG_RDATA_O <= 16'h0000;
            if (REG_RD_I)
            begin
                case (REG_ADDR_I)
                    `PCC_REG_CONFIG: REG_RDATA_O <= config_reg;
                    `PCC_REG_STATUS: REG_RDATA_O <= {cycle_start_latch, read_delayed,
                                                     reply_reject_latch, reply_reject_enable,
                                                     strobe_request, done_pending,
                                                     request_alarm_interrupt,
                                                     request_done_interrupt,
                                                     status_word[7:0]};
                    `PCC_REG_CHAR:   REG_RDATA_O <= {7'h00, PRN_PARITY_O, PRN_DATA_O};
                    default:         REG_RDATA_O <= 16'h0000;
                endcase
            end
        end
    end

endmodule

/* src/pcc_defs.vh */
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH

// Timing: the phase clock is the system clock divided into four phases
`define PCC_CLK_PERIOD_NS    100
`define PCC_PHASE_NS         100
`define PCC_PHASE_CYCLES     (`PCC_PHASE_NS / `PCC_CLK_PERIOD_NS)
`define PCC_ROUND_NS         400
`define PCC_ROUND_CYCLES     (`PCC_ROUND_NS / `PCC_CLK_PERIOD_NS)
`define PCC_STROBE_T4_COUNT  3'h4

// Phase vector positions
`define PCC_T1               0
`define PCC_T2               1
`define PCC_T3               2
`define PCC_T4               3

// Register indices on the local port
`define PCC_REG_CONFIG       4'h0
`define PCC_REG_STATUS       4'h1
`define PCC_REG_CHAR         4'h2
`define PCC_CONFIG_RESET     16'h0000

// Config fields
`define PCC_CFG_EQ_LSB       0
`define PCC_CFG_EQ_MSB       3
`define PCC_CFG_PROTECT_JMP  4

// Channel bit positions
`define PCC_Q_OP             0
`define PCC_Q_EQ_LSB         7
`define PCC_Q_EQ_MSB         10
`define PCC_Q_UPPER_LSB      11
`define PCC_Q_UPPER_MSB      15
`define PCC_A_CLEAR_CTRL     0
`define PCC_A_CLEAR_INT      1
`define PCC_A_RQ_CHAR        2
`define PCC_A_RQ_DONE        3
`define PCC_A_RQ_ALARM       4
`define PCC_A_PRINT          5

`endif

/* src/pcc_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for the channel strobes
module pcc_sync
#(
    parameter W = 2
)
(
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);

    reg [W-1:0] stage1;

    // First stage feeds only the second
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage1 <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

/* src/pcc_phase_gen.v */
`timescale 1ns/1ps
`include "pcc_defs.vh"
// Johnson counter giving four non-overlapping phases T1..T4
module pcc_phase_gen
(
    input  wire       clk_i,
    input  wire       rst_i,
    output reg  [3:0] phase_o
);

    reg  [1:0] johnson;
    wire [1:0] next_johnson;
    reg  [3:0] next_phase;

    // Shift with inverted feedback: 00, 01, 11, 10
    assign next_johnson = {johnson[0], ~johnson[1]};

    // Decode the coming state so the phases leave a flip-flop
    always @*
    begin
        next_phase = 4'h0;
        case (next_johnson)
            2'b00: next_phase[`PCC_T1] = 1'b1;
            2'b01: next_phase[`PCC_T2] = 1'b1;
            2'b11: next_phase[`PCC_T3] = 1'b1;
            2'b10: next_phase[`PCC_T4] = 1'b1;
            default: next_phase = 4'h0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            johnson <= 2'b10;
            phase_o <= 4'h0;
        end
        else
        begin
            johnson <= next_johnson;
            phase_o <= next_phase;
        end
    end

endmodule

/* tb/pcc_host_channel_assertions.sv */
`timescale 1ns/1ps
// Watches channel answers and interrupt lines at the top ports only
module pcc_host_channel_chk
(
    input wire        CLK_SYS_I,
    input wire        SYS_RST_I,
    input wire        AQ_READ_N_I,
    input wire        AQ_WRITE_N_I,
    input wire        AQ_PROTECT_N_I,
    input wire [15:0] AQ_Q_I,
    input wire [15:0] AQ_A_O,
    input wire        AQ_A_OE_O,
    input wire        AQ_REPLY_O,
    input wire        AQ_REJECT_O,
    input wire        INT_CHAR_O,
    input wire        DONE_INTERRUPT_LINE_O,
    input wire        INT_ALARM_O,
    input wire        INT_COMMON_O,
    input wire [3:0]  REG_ADDR_I,
    input wire [15:0] REG_WDATA_I,
    input wire        REG_WR_I
);
    reg  [4:0] cfg;
    wire       act;
    wire       hit;
    wire       ans;
    wire       any;
    // Shadow of the jumper word; an installed jumper compares as a low
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
            cfg <= 5'h00;
        else if (REG_WR_I && REG_ADDR_I == 4'h0)
            cfg <= REG_WDATA_I[4:0];
    end
    // Strobe, address match, answer and interrupt summaries
    assign act = !AQ_READ_N_I || !AQ_WRITE_N_I;
    assign hit = AQ_Q_I[10:7] == ~cfg[3:0] && AQ_Q_I[15:11] == 5'h00;
    assign ans = AQ_REPLY_O || AQ_REJECT_O;
    assign any = INT_CHAR_O || DONE_INTERRUPT_LINE_O || INT_ALARM_O;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    // Start of an addressed cycle
    sequence s_start;
        $rose(act) && hit;
    endsequence
    chk_status_reply: assert property (
        s_start ##0 (!AQ_READ_N_I && AQ_Q_I[0]) |-> ##[3:10] AQ_REPLY_O)
        else $error("status read not replied");
    chk_illegal_reject: assert property (
        s_start ##0 (!AQ_READ_N_I && !AQ_Q_I[0]) |-> ##[3:10] AQ_REJECT_O)
        else $error("illegal read not refused");
    chk_protect_reject: assert property (
        s_start ##0 (!AQ_WRITE_N_I && !cfg[4] && AQ_PROTECT_N_I) |-> ##[3:10] AQ_REJECT_O)
        else $error("unprotected write not refused");
    chk_no_stray: assert property (
        ($rose(act) && !hit) |-> (!ans)[*8])
        else $error("answer to another address");
    chk_answer_cause: assert property (
        $rose(ans) |-> $past(act) && $past(act, 3))
        else $error("answer without a settled strobe");
    chk_answer_hold: assert property (
        (ans && act) |=> ans)
        else $error("answer dropped under strobe");
    chk_answer_release: assert property (
        $fell(act) |-> ##[1:4] !ans)
        else $error("answer kept after strobe");
    chk_reply_excl: assert property (
        !(AQ_REPLY_O && AQ_REJECT_O))
        else $error("reply and reject together");
    chk_status_drive: assert property (
        ($rose(AQ_REPLY_O) && !AQ_READ_N_I && AQ_Q_I[0]) |-> AQ_A_OE_O)
        else $error("status not driven");
    chk_status_stable: assert property (
        (AQ_REPLY_O && $past(AQ_REPLY_O) && AQ_A_OE_O) |-> $stable(AQ_A_O))
        else $error("status moved under reply");
    chk_common_line: assert property (
        any |-> ##[0:1] INT_COMMON_O)
        else $error("common interrupt missing");
endmodule

bind pcc_host_channel pcc_host_channel_chk i_pcc_host_channel_chk
(
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .AQ_READ_N_I(AQ_READ_N_I),
    .AQ_WRITE_N_I(AQ_WRITE_N_I), .AQ_PROTECT_N_I(AQ_PROTECT_N_I), .AQ_Q_I(AQ_Q_I),
    .AQ_A_O(AQ_A_O), .AQ_A_OE_O(AQ_A_OE_O), .AQ_REPLY_O(AQ_REPLY_O),
    .AQ_REJECT_O(AQ_REJECT_O), .INT_CHAR_O(INT_CHAR_O), .INT_ALARM_O(INT_ALARM_O),
    .DONE_INTERRUPT_LINE_O(DONE_INTERRUPT_LINE_O), .INT_COMMON_O(INT_COMMON_O),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I)
);

/* tb/pcc_host_model.sv */
`timescale 1ns/1ps
// Host end of the channel: one transfer at a time, answered or timed out
module pcc_host_model
(
    input  wire        clk_i,
    input  wire        reply_i,
    input  wire        reject_i,
    input  wire [15:0] a_i,
    output reg         read_n_o,
    output reg         write_n_o,
    output reg  [15:0] q_o,
    output reg  [15:0] a_o
);
    // Idle: strobes off, Q upper bits set so nothing is addressed
    initial
    begin
        read_n_o = 1'b1;
        write_n_o = 1'b1;
        q_o = 16'hFFFF;
        a_o = 16'h5A5A;
    end
    // Codes: 0 none, 1 Reply, 2 Reject; status word taken with Reply
    task xfer(input wr, input [15:0] q, input [15:0] a, output [1:0] r, output [15:0] st);
        integer n;
    begin
        r = 2'd0;
        st = 16'h0000;
        @(posedge clk_i);
        q_o <= q;
        a_o <= a;
        read_n_o <= wr;
        write_n_o <= !wr;
        for (n = 0; n < 16 && r == 2'd0; n = n + 1)
        begin
            @(posedge clk_i);
            if (reply_i)
                st = a_i;
            r = reply_i ? 2'd1 : (reject_i ? 2'd2 : 2'd0);
        end
        // Dropping the strobe ends the cycle; wait for the answer to clear
        read_n_o <= 1'b1;
        write_n_o <= 1'b1;
        for (n = 0; n < 8 && (reply_i || reject_i); n = n + 1)
            @(posedge clk_i);
        // Released words must not look still valid
        q_o <= ~q;
        a_o <= ~a;
    end
    endtask
endmodule

/* tb/tb_pcc_host_channel.sv */
`timescale 1ns/1ps
// Channel block with a host model, register master and printer stand-in
module tb_pcc_host_channel;
    localparam [15:0] QS = 16'h0501; // Equipment 10, op bit set
    localparam [15:0] QD = 16'h0500; // Equipment 10, op bit clear
    reg         clk;
    reg         rst;
    reg         prot_n;
    reg         rdy;
    reg         lrdy;
    reg         creq;
    reg  [3:0]  r_addr;
    reg  [15:0] r_wd;
    reg         r_wr;
    reg         r_rd;
    wire [15:0] r_rdata;
    wire        rd_n;
    wire        wr_n;
    wire [15:0] q;
    wire [15:0] a_in;
    wire [15:0] a_out;
    wire        reply;
    wire        reject;
    wire        i_alarm;
    wire        i_com;
    wire        i_chr;
    wire        i_done;
    wire        p_bclr;
    wire [7:0]  p_data;
    wire        p_par;
    wire        p_ctl;
    wire        p_stb;
    reg  [1:0]  r;
    reg  [15:0] stat;
    reg         perr;
    reg         bclr;
    integer     errors;
    integer     checks_done;
    integer     cycles;
    integer     n;
    pcc_host_channel i_pcc_host_channel
    (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .AQ_READ_N_I(rd_n), .AQ_WRITE_N_I(wr_n),
        .AQ_PROTECT_N_I(prot_n), .AQ_Q_I(q), .AQ_A_I(a_in), .AQ_A_O(a_out),
        .AQ_A_OE_O(), .AQ_REPLY_O(reply), .AQ_REJECT_O(reject), .INT_CHAR_O(i_chr),
        .DONE_INTERRUPT_LINE_O(i_done), .INT_ALARM_O(i_alarm), .INT_COMMON_O(i_com),
        .PRN_READY_I(rdy), .PRN_LINE_READY_I(lrdy), .PRN_CHAR_REQ_I(creq),
        .PRN_PARITY_ERR_I(perr), .PRN_DATA_O(p_data), .PRN_PARITY_O(p_par),
        .PRN_CONTROL_BIT_O(p_ctl), .PRN_STROBE_O(p_stb), .PRN_BUFFER_CLEAR_O(p_bclr),
        .REG_ADDR_I(r_addr), .REG_WDATA_I(r_wd), .REG_WR_I(r_wr), .REG_RD_I(r_rd),
        .REG_RDATA_O(r_rdata)
    );
    pcc_host_model i_pcc_host_model
    (
        .clk_i(clk), .reply_i(reply), .reject_i(reject), .a_i(a_out),
        .read_n_o(rd_n), .write_n_o(wr_n), .q_o(q), .a_o(a_in)
    );
    // 10 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task check(input [15:0] seen, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task final_report;
    begin
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // Register master: one-cycle strobes, read data in the next cycle
    task reg_wr(input [3:0] ad, input [15:0] d);
    begin
        @(posedge clk);
        r_addr <= ad;
        r_wd <= d;
        r_wr <= 1'b1;
        @(posedge clk);
        r_wr <= 1'b0;
    end
    endtask
    task reg_rd(input [3:0] ad, input [15:0] exp);
    begin
        @(posedge clk);
        r_addr <= ad;
        r_rd <= 1'b1;
        @(posedge clk);
        r_rd <= 1'b0;
        @(posedge clk);
        check(r_rdata, exp);
    end
    endtask
    // One channel cycle with its expected answer code
    task cyc(input wr, input [15:0] qv, input [15:0] av, input [1:0] exp);
    begin
        i_pcc_host_model.xfer(wr, qv, av, r, stat);
        check({14'h0000, r}, {14'h0000, exp});
        repeat (2) @(posedge clk);
    end
    endtask
    // Printer takes the strobed word; optional print cycle on line ready
    task prn_take(input lr);
    begin
        for (n = 0; n < 60 && p_stb !== 1'b1; n = n + 1)
            @(posedge clk);
        check({15'h0000, p_stb}, 16'h0001);
        creq <= 1'b0;
        lrdy <= !lr;
        repeat (8) @(posedge clk);
        check({15'h0000, p_stb}, 16'h0000);
        creq <= 1'b1;
        lrdy <= 1'b1;
        repeat (4) @(posedge clk);
    end
    endtask
    // Hang guard; also catches the one-cycle buffer clear pulse
    always @(posedge clk)
    begin
        if (p_bclr === 1'b1)
            bclr = 1'b1;
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            errors = errors + 1;
            final_report;
        end
    end
    initial
    begin
        {errors, checks_done, cycles} = 0;
        {rst, prot_n, rdy, lrdy, creq} = 5'b10110;
        {r_addr, r_wd, r_wr, r_rd} = 0;
        {perr, bclr} = 2'b00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        creq <= 1'b1;
        reg_rd(4'h0, 16'h0000);
        reg_rd(4'hF, 16'h0000);
        reg_wr(4'h0, 16'h0015);
        reg_rd(4'h0, 16'h0015);
        cyc(1'b0, QS, 16'h0000, 2'd1);
        check(stat & 16'hFF81, 16'h0081);
        cyc(1'b0, 16'h0481, 16'h0000, 2'd0);
        cyc(1'b0, 16'h0D01, 16'h0000, 2'd0);
        cyc(1'b0, QD, 16'h0000, 2'd2);
        $display("addressing test done");
        cyc(1'b1, QD, 16'h00A5, 2'd1);
        check({8'h00, p_data}, 16'h00A5);
        check({15'h0000, p_par}, 16'h0001);
        prn_take(1'b0);
        $display("data write test done");
        cyc(1'b1, QS, 16'h0010, 2'd1);
        rdy <= 1'b0;
        repeat (4) @(posedge clk);
        check({14'h0000, i_alarm, i_com}, 16'h0003);
        cyc(1'b1, QD, 16'h0041, 2'd2);
        cyc(1'b1, QS, 16'h0012, 2'd1);
        check({15'h0000, i_alarm}, 16'h0001);
        cyc(1'b1, QS, 16'h0002, 2'd1);
        check({15'h0000, i_alarm}, 16'h0000);
        rdy <= 1'b1;
        $display("interrupt test done");
        cyc(1'b1, QS, 16'h0028, 2'd1);
        check({15'h0000, p_ctl}, 16'h0001);
        cyc(1'b1, QS, 16'h0020, 2'd2);
        prn_take(1'b1);
        $display("print test done");
        cyc(1'b1, QS, 16'h0014, 2'd1);
        perr <= 1'b1;
        @(posedge clk);
        perr <= 1'b0;
        repeat (2) @(posedge clk);
        check({12'h000, i_chr, i_done, i_alarm, bclr}, 16'h000E);
        cyc(1'b1, QS, 16'h0001, 2'd1);
        check({12'h000, i_chr, i_done, i_alarm, bclr}, 16'h0001);
        $display("clear test done");
        reg_wr(4'h0, 16'h0005);
        prot_n <= 1'b1;
        cyc(1'b1, QS, 16'h0000, 2'd2);
        cyc(1'b0, QS, 16'h0000, 2'd1);
        prot_n <= 1'b0;
        cyc(1'b1, QS, 16'h0000, 2'd1);
        $display("protect test done");
        final_report;
    end
endmodule
